// >>> shared/fbs_pkg.sv
// Constants shared by the fieldbus slave state logic.
// Assumes a single 100 MHz clock domain.
package fbs_pkg;
	localparam logic [15:0] ETHERTYPE_FB   = 16'h88a4;
	localparam int          ETYPE_HI_POS   = 12;
	localparam int          ETYPE_LO_POS   = 13;
	localparam int          HDR_LEN        = 14;
	localparam int          PD_LEN_DEF     = 50;
	localparam int          MBX_LEN_DEF    = 16;
	localparam logic [10:0] MBX_OFF        = 11'h00e;
	localparam logic [3:0]  AL_INIT        = 4'h1;
	localparam logic [3:0]  AL_PREOP       = 4'h2;
	localparam logic [3:0]  AL_BOOT        = 4'h3;
	localparam logic [3:0]  AL_SAFEOP      = 4'h4;
	localparam logic [3:0]  AL_OP          = 4'h8;
	localparam logic [10:0] MAP_OFF_RST    = 11'h01e;
	localparam logic [15:0] CYC_RST        = 16'h0001;
	localparam int          CLK_MHZ        = 100;
	localparam int          CYCLE_US_DEF   = 1;
	localparam int          CYCLE_CLKS_DEF = CYCLE_US_DEF * CLK_MHZ;
	typedef enum logic [2:0] {ST_INIT, ST_PREOP, ST_COPY, ST_SAFEOP, ST_OP} fbs_state_t;
endpackage : fbs_pkg

// >>> rtl/fbs_slave_sm.sv
// Slave state logic of a daisy-chained real-time Ethernet fieldbus node.
// Assumes byte streams on clock_i from the MAC logic; dn_link_i is a pin.
// How it works
// - Extract addressed bytes from each passing telegram, insert own data, forward it.
// - With no downstream node, send the telegram back toward the master.
// - Fieldbus telegrams are recognised by frame type 0x88A4.
// - Power-on enters Init; mailbox and process data blocked.
// - Init to Pre-Op checks mailbox channel configuration first.
// - Pre-Op serves mailbox traffic only, no process data.
// - Pre-Op to Safe-Op checks process data channel configuration.
// - Copy current output data into transmit memory before acknowledging Safe-Op.
// - Safe-Op: mailbox and process data active, outputs refreshed, inputs zero.
// - Op: received data to input set 1, output set 1 to telegram.
// - Bootstrap state and its transition are refused.
// - Op falling to Pre-Op or Init halts updates, and mailbox too when going to Init; to Safe-Op only the inputs go zero.
// - Safe-Op to Init halts input updating and mailbox together.
// - Mapping and assignment objects select which bytes travel as process data.
// - Sync manager objects set the refresh cycle time and sync form.
// - Mailbox gives master access to the object directory.
`timescale 1ns/10ps
`default_nettype none
module fbs_slave_sm
	import fbs_pkg::*;
#(
	parameter int PD_LEN  = PD_LEN_DEF,
	parameter int MBX_LEN = MBX_LEN_DEF
) (
	input  wire logic                      clock_i,
	input  wire logic                      rst_i,
	input  wire logic                      rx_valid_i,
	input  wire logic [7:0]                rx_data_i,
	input  wire logic                      rx_sof_i,
	input  wire logic                      rx_eof_i,
	input  wire logic                      dn_link_i,
	input  wire logic                      dn_valid_i,
	input  wire logic [7:0]                dn_data_i,
	input  wire logic                      dn_sof_i,
	input  wire logic                      dn_eof_i,
	input  wire logic                      al_req_stb_i,
	input  wire logic [3:0]                al_req_i,
	input  wire logic                      sm_mbx_ok_i,
	input  wire logic                      sm_pd_ok_i,
	input  wire logic [10:0]               map_off_i,
	input  wire logic [10:0]               map_len_i,
	input  wire logic [15:0]               sm_cycle_i,
	input  wire logic                      sm_sync_i,
	input  wire logic                      out_wr_i,
	input  wire logic [$clog2(PD_LEN)-1:0] out_addr_i,
	input  wire logic [7:0]                out_data_i,
	output logic                           fw_valid_o,
	output logic [7:0]                     fw_data_o,
	output logic                           fw_sof_o,
	output logic                           fw_eof_o,
	output logic                           up_valid_o,
	output logic [7:0]                     up_data_o,
	output logic                           up_sof_o,
	output logic                           up_eof_o,
	output logic [3:0]                     al_state_o,
	output logic                           al_ack_o,
	output logic                           al_err_o,
	output logic                           mbx_on_o,
	output logic                           mbx_wr_o,
	output logic                           mbx_sof_o,
	output logic [7:0]                     mbx_data_o,
	output logic                           ds1_wr_o,
	output logic [$clog2(PD_LEN)-1:0]      ds1_addr_o,
	output logic [7:0]                     ds1_data_o
);
	localparam int AW = $clog2(PD_LEN);
	localparam logic [AW-1:0] PD_LAST = AW'(PD_LEN - 1);
	localparam logic [10:0]   PD_LEN_W = 11'(PD_LEN);
	localparam logic [10:0]   MBX_LEN_W = 11'(MBX_LEN);

	function automatic logic in_win(input logic [10:0] pos,
	                                input logic [10:0] off,
	                                input logic [10:0] len);
		in_win = (pos >= off) && (pos < off + len);
	endfunction : in_win

	fbs_state_t  st_r;
	fbs_state_t  st_nxt;
	logic        link_s1_r;
	logic        link_s2_r;
	logic [10:0] cnt_r;
	logic        hi_ok_r;
	logic        type_ok_r;
	logic [10:0] map_off_r;
	logic [10:0] map_len_r;
	logic [15:0] cyc_cnt_r;
	logic        cp_busy_r;
	logic [AW-1:0] cp_ptr_r;
	logic [7:0]  stage_r [PD_LEN];
	logic [7:0]  dpram_r [PD_LEN];
	logic        ack_nxt;
	logic        err_nxt;
	logic        latch_map;

	// Stream decode
	wire logic [10:0]   cur      = rx_sof_i ? 11'h000 : cnt_r;
	wire logic          mbx_act  = (st_r == ST_PREOP) || (st_r == ST_COPY) ||
	                               (st_r == ST_SAFEOP) || (st_r == ST_OP);
	wire logic          pd_act   = (st_r == ST_SAFEOP) || (st_r == ST_OP);
	wire logic          fb_frame = rx_valid_i && type_ok_r;
	wire logic          pd_hit   = fb_frame && pd_act && in_win(cur, map_off_r, map_len_r);
	wire logic          mbx_hit  = fb_frame && mbx_act && in_win(cur, MBX_OFF, MBX_LEN_W);
	wire logic [10:0]   pd_diff  = cur - map_off_r;
	wire logic [AW-1:0] pd_idx   = pd_diff[AW-1:0];
	wire logic [7:0]    proc_dat = pd_hit ? dpram_r[pd_idx] : rx_data_i;
	wire logic          last_node = !link_s2_r;

	// Refresh timing
	wire logic tick      = (cyc_cnt_r == 16'h0000);
	wire logic frame_end = rx_valid_i && rx_eof_i && type_ok_r;
	wire logic refresh   = sm_sync_i ? frame_end : tick;
	wire logic cp_enter  = (st_r != ST_COPY) && (st_nxt == ST_COPY);
	wire logic cp_start  = !cp_busy_r && (cp_enter || (pd_act && refresh));
	wire logic cp_done   = cp_busy_r && (cp_ptr_r == PD_LAST);

	// Checks made on a requested change
	wire logic mbx_cfg_ok = sm_mbx_ok_i;
	wire logic pd_cfg_ok  = sm_pd_ok_i && (map_len_i != 11'h000) &&
	                        (map_len_i <= PD_LEN_W) && (map_off_i >= 11'(HDR_LEN));

	// State requests from the master
	always_comb begin
		st_nxt    = st_r;
		ack_nxt   = 1'b0;
		err_nxt   = 1'b0;
		latch_map = 1'b0;
		case (st_r)
			ST_INIT: begin
				if (al_req_stb_i) begin
					if (al_req_i == AL_INIT) begin
						ack_nxt = 1'b1;
					end else if (al_req_i == AL_PREOP && mbx_cfg_ok) begin
						st_nxt  = ST_PREOP;
						ack_nxt = 1'b1;
					end else begin
						err_nxt = 1'b1;
					end
				end
			end
			ST_PREOP: begin
				if (al_req_stb_i) begin
					if (al_req_i == AL_INIT) begin
						st_nxt  = ST_INIT;
						ack_nxt = 1'b1;
					end else if (al_req_i == AL_PREOP) begin
						ack_nxt = 1'b1;
					end else if (al_req_i == AL_SAFEOP && pd_cfg_ok) begin
						st_nxt    = ST_COPY;
						latch_map = 1'b1;
					end else begin
						err_nxt = 1'b1;
					end
				end
			end
			ST_COPY: begin
				if (cp_done) begin
					st_nxt  = ST_SAFEOP;
					ack_nxt = 1'b1;
				end else if (al_req_stb_i) begin
					err_nxt = 1'b1;
				end
			end
			ST_SAFEOP: begin
				if (al_req_stb_i) begin
					ack_nxt = 1'b1;
					if (al_req_i == AL_INIT) begin
						st_nxt = ST_INIT;
					end else if (al_req_i == AL_PREOP) begin
						st_nxt = ST_PREOP;
					end else if (al_req_i == AL_OP) begin
						st_nxt = ST_OP;
					end else if (al_req_i != AL_SAFEOP) begin
						ack_nxt = 1'b0;
						err_nxt = 1'b1;
					end
				end
			end
			ST_OP: begin
				if (al_req_stb_i) begin
					ack_nxt = 1'b1;
					if (al_req_i == AL_INIT) begin
						st_nxt = ST_INIT;
					end else if (al_req_i == AL_PREOP) begin
						st_nxt = ST_PREOP;
					end else if (al_req_i == AL_SAFEOP) begin
						st_nxt = ST_SAFEOP;
					end else if (al_req_i != AL_OP) begin
						ack_nxt = 1'b0;
						err_nxt = 1'b1;
					end
				end
			end
			default: begin
				st_nxt = ST_INIT;
			end
		endcase
	end

	wire logic [3:0] code_nxt = (st_nxt == ST_PREOP || st_nxt == ST_COPY) ? AL_PREOP :
	                            (st_nxt == ST_SAFEOP) ? AL_SAFEOP :
	                            (st_nxt == ST_OP) ? AL_OP : AL_INIT;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			st_r       <= ST_INIT;
			al_state_o <= AL_INIT;
			al_ack_o   <= 1'b0;
			al_err_o   <= 1'b0;
			mbx_on_o   <= 1'b0;
		end else begin
			st_r       <= st_nxt;
			al_state_o <= code_nxt;
			al_ack_o   <= ack_nxt;
			al_err_o   <= err_nxt;
			mbx_on_o   <= (st_nxt != ST_INIT);
		end
	end

	// Mapping latched when the change to Safe-Op is accepted
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			map_off_r <= MAP_OFF_RST;
			map_len_r <= 11'h000;
		end else if (latch_map) begin
			map_off_r <= map_off_i;
			map_len_r <= map_len_i;
		end
	end

	// Downstream presence pin synchroniser
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			link_s1_r <= 1'b0;
			link_s2_r <= 1'b0;
		end else begin
			link_s1_r <= dn_link_i;
			link_s2_r <= link_s1_r;
		end
	end

	// Byte position and frame type recognition
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r     <= 11'h000;
			hi_ok_r   <= 1'b0;
			type_ok_r <= 1'b0;
		end else if (rx_valid_i) begin
			cnt_r <= (cur == 11'h7ff) ? cur : cur + 11'h001;
			if (rx_sof_i) begin
				hi_ok_r   <= 1'b0;
				type_ok_r <= 1'b0;
			end else if (cur == 11'(ETYPE_HI_POS)) begin
				hi_ok_r <= (rx_data_i == ETHERTYPE_FB[15:8]);
			end else if (cur == 11'(ETYPE_LO_POS)) begin
				type_ok_r <= hi_ok_r && (rx_data_i == ETHERTYPE_FB[7:0]);
			end
		end
	end

	// Forward downstream, or turn the telegram back at the last node
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			fw_valid_o <= 1'b0;
			fw_data_o  <= 8'h00;
			fw_sof_o   <= 1'b0;
			fw_eof_o   <= 1'b0;
			up_valid_o <= 1'b0;
			up_data_o  <= 8'h00;
			up_sof_o   <= 1'b0;
			up_eof_o   <= 1'b0;
		end else begin
			fw_valid_o <= rx_valid_i && !last_node;
			fw_data_o  <= proc_dat;
			fw_sof_o   <= rx_valid_i && rx_sof_i && !last_node;
			fw_eof_o   <= rx_valid_i && rx_eof_i && !last_node;
			up_valid_o <= last_node ? rx_valid_i : dn_valid_i;
			up_data_o  <= last_node ? proc_dat : dn_data_i;
			up_sof_o   <= last_node ? (rx_valid_i && rx_sof_i) : (dn_valid_i && dn_sof_i);
			up_eof_o   <= last_node ? (rx_valid_i && rx_eof_i) : (dn_valid_i && dn_eof_i);
		end
	end

	// Extracted data towards the gateway: mailbox and input data set 1
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			mbx_wr_o   <= 1'b0;
			mbx_sof_o  <= 1'b0;
			mbx_data_o <= 8'h00;
			ds1_wr_o   <= 1'b0;
			ds1_addr_o <= '0;
			ds1_data_o <= 8'h00;
		end else begin
			mbx_wr_o   <= mbx_hit;
			mbx_sof_o  <= mbx_hit && (cur == MBX_OFF);
			mbx_data_o <= rx_data_i;
			ds1_wr_o   <= pd_hit;
			ds1_addr_o <= pd_idx;
			ds1_data_o <= (st_r == ST_OP) ? rx_data_i : 8'h00;
		end
	end

	// Refresh period from the sync manager cycle setting
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cyc_cnt_r <= CYC_RST;
		end else if (tick) begin
			cyc_cnt_r <= (sm_cycle_i == 16'h0000) ? 16'h0000 : sm_cycle_i - 16'h0001;
		end else begin
			cyc_cnt_r <= cyc_cnt_r - 16'h0001;
		end
	end

	// Copy of output data set 1 into the transmit memory
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cp_busy_r <= 1'b0;
			cp_ptr_r  <= '0;
		end else if (cp_start) begin
			cp_busy_r <= 1'b1;
			cp_ptr_r  <= '0;
		end else if (cp_done) begin
			cp_busy_r <= 1'b0;
		end else if (cp_busy_r) begin
			cp_ptr_r <= cp_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < PD_LEN; i++) begin
				stage_r[i] <= 8'h00;
				dpram_r[i] <= 8'h00;
			end
		end else begin
			if (out_wr_i && (out_addr_i <= PD_LAST)) begin
				stage_r[out_addr_i] <= out_data_i;
			end
			if (cp_busy_r) begin
				dpram_r[cp_ptr_r] <= stage_r[cp_ptr_r];
			end
		end
	end
endmodule : fbs_slave_sm
`default_nettype wire

// >>> tb/fbs_slave_sm_sva.sv
// Checker for the fieldbus slave state logic, bound to its ports.
// Assumes one clock domain with an async active-high reset.
`timescale 1ns/10ps
`default_nettype none
module fbs_slave_sm_sva
	import fbs_pkg::*;
#(
	parameter int PD_LEN = PD_LEN_DEF
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic dn_link_i,
	input wire logic al_req_stb_i,
	input wire logic [3:0] al_req_i,
	input wire logic sm_mbx_ok_i,
	input wire logic sm_pd_ok_i,
	input wire logic [10:0] map_off_i,
	input wire logic [10:0] map_len_i,
	input wire logic fw_valid_o,
	input wire logic up_valid_o,
	input wire logic [3:0] al_state_o,
	input wire logic al_ack_o,
	input wire logic al_err_o,
	input wire logic mbx_on_o,
	input wire logic ds1_wr_o,
	input wire logic [7:0] ds1_data_o
);
	localparam int CP_LO = PD_LEN + 1;
	localparam int CP_HI = PD_LEN + 2;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	sequence s_go_safe;
		al_req_stb_i && al_req_i == AL_SAFEOP && al_state_o == AL_PREOP && sm_pd_ok_i
			&& map_off_i >= 11'h00e && map_len_i != 11'h000 && map_len_i <= PD_LEN;
	endsequence
	sequence s_copy_done;
		##[CP_LO:CP_HI] (al_ack_o && al_state_o == AL_SAFEOP);
	endsequence
	AST_BOOT: assert property (al_req_stb_i && al_req_i == AL_BOOT
		&& al_state_o == AL_INIT |=> al_err_o && !al_ack_o && al_state_o == AL_INIT)
		else $error("boot request not refused");
	AST_MBX_CHECK: assert property (al_req_stb_i && al_req_i == AL_PREOP
		&& al_state_o == AL_INIT |=> al_ack_o == $past(sm_mbx_ok_i) && al_err_o != al_ack_o
		&& al_state_o == ($past(sm_mbx_ok_i) ? AL_PREOP : AL_INIT)) else $error("init exit wrong");
	AST_PD_CHECK: assert property (al_req_stb_i && al_req_i == AL_SAFEOP && !sm_pd_ok_i
		&& al_state_o == AL_PREOP |=> al_err_o && al_state_o == AL_PREOP)
		else $error("bad channels accepted");
	AST_SAFEOP: assert property (s_go_safe |-> s_copy_done)
		else $error("safe state ack out of window");
	AST_MBX_LEVEL: assert property (mbx_on_o == (al_state_o != AL_INIT))
		else $error("mailbox enable wrong");
	AST_PD_GATE: assert property (ds1_wr_o |-> $past(al_state_o) == AL_SAFEOP
		|| $past(al_state_o) == AL_OP) else $error("process data outside exchange");
	AST_ZERO: assert property (ds1_wr_o && $past(al_state_o) == AL_SAFEOP
		|-> ds1_data_o == 8'h00) else $error("input not zero");
	AST_OP_COPY: assert property (ds1_wr_o && $past(al_state_o) == AL_OP
		|-> ds1_data_o == $past(rx_data_i)) else $error("input copy wrong");
	AST_RET: assert property (rx_valid_i && !dn_link_i && !$past(dn_link_i)
		&& !$past(dn_link_i, 2) && !$past(dn_link_i, 3) |=> up_valid_o && !fw_valid_o)
		else $error("no return at last node");
endmodule : fbs_slave_sm_sva
bind fbs_slave_sm fbs_slave_sm_sva #(.PD_LEN(PD_LEN)) sva_u (.*);
`default_nettype wire

// >>> tb/fbs_master_model.sv
// Master model: sends telegrams, channel settings and state requests.
// Assumes clock_i is shared with the slave; drives on falling edges.
`timescale 1ns/10ps
`default_nettype none
module fbs_master_model
	import fbs_pkg::*;
(
	input wire logic clock_i,
	output var logic rx_valid_i,
	output var logic [7:0] rx_data_i,
	output var logic rx_sof_i,
	output var logic rx_eof_i,
	output var logic al_req_stb_i,
	output var logic [3:0] al_req_i,
	output var logic sm_mbx_ok_i,
	output var logic sm_pd_ok_i,
	output var logic [10:0] map_off_i,
	output var logic [10:0] map_len_i
);
	initial begin
		rx_valid_i = 1'b0;
		rx_data_i = 8'h00;
		rx_sof_i = 1'b0;
		rx_eof_i = 1'b0;
		al_req_stb_i = 1'b0;
		al_req_i = AL_INIT;
		sm_mbx_ok_i = 1'b0;
		sm_pd_ok_i = 1'b0;
		map_off_i = MAP_OFF_RST;
		map_len_i = 11'h004;
	end
	task automatic cfg(input logic mbx, input logic pd);
		@(negedge clock_i);
		sm_mbx_ok_i = mbx;
		sm_pd_ok_i = pd;
	endtask : cfg
	task automatic req(input logic [3:0] code);
		@(negedge clock_i);
		al_req_i = code;
		al_req_stb_i = 1'b1;
		@(negedge clock_i);
		al_req_stb_i = 1'b0;
	endtask : req
	task automatic frame(input int n, input logic [15:0] ty);
		for (int i = 0; i < n; i++) begin
			@(negedge clock_i);
			rx_valid_i = 1'b1;
			rx_sof_i = (i == 0);
			rx_eof_i = (i == n - 1);
			rx_data_i = i == 12 ? ty[15:8] : i == 13 ? ty[7:0] : 8'(8'h40 + i);
		end
		@(negedge clock_i);
		rx_valid_i = 1'b0;
		rx_sof_i = 1'b0;
		rx_eof_i = 1'b0;
		// Released line shows the inverse, never a stale byte
		rx_data_i = ~rx_data_i;
	endtask : frame
endmodule : fbs_master_model
`default_nettype wire

// >>> tb/fbs_slave_sm_tb_top.sv
// Testbench: master model drives the slave, downstream loops fw back.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/10ps
`default_nettype none
module fbs_slave_sm_tb_top;
	import fbs_pkg::*;
	localparam int PD = 8;
	logic clock_i, rst_i, dn_link_i, out_wr_i, rx_valid_i, rx_sof_i, rx_eof_i;
	logic al_req_stb_i, sm_mbx_ok_i, sm_pd_ok_i, fw_valid_o, fw_sof_o, fw_eof_o;
	logic up_valid_o, up_sof_o, up_eof_o, al_ack_o, al_err_o, mbx_on_o;
	logic mbx_wr_o, mbx_sof_o, ds1_wr_o;
	logic [7:0] rx_data_i, out_data_i, fw_data_o, up_data_o, mbx_data_o, ds1_data_o;
	logic [3:0] al_req_i, al_state_o;
	logic [10:0] map_off_i, map_len_i;
	logic [$clog2(PD)-1:0] out_addr_i, ds1_addr_o;
	logic [15:0] sm_cycle_i = 16'h0000;
	logic sm_sync_i = 1'b0;
	wire dn_valid_i = fw_valid_o;
	wire [7:0] dn_data_i = fw_data_o;
	wire dn_sof_i = fw_sof_o;
	wire dn_eof_i = fw_eof_o;
	logic [7:0] fwq[$], upq[$], dsq[$];
	int miscompares = 0;
	int n_checks = 0;
	int nmbx = 0;
	int nfs = 0;
	int nue = 0;
	logic [7:0] mfirst = 8'h00;
	logic [7:0] daq[$];
	fbs_slave_sm #(.PD_LEN(PD)) dut_u (.*);
	fbs_master_model mm_u (.*);
	always @(posedge clock_i) begin
		if (fw_valid_o) fwq.push_back(fw_data_o);
		if (up_valid_o) upq.push_back(up_data_o);
		if (ds1_wr_o) dsq.push_back(ds1_data_o);
		if (mbx_wr_o) nmbx++;
		if (mbx_wr_o && mbx_sof_o) mfirst = mbx_data_o;
		if (ds1_wr_o) daq.push_back(8'(ds1_addr_o));
		if (fw_valid_o && fw_sof_o) nfs++;
		if (up_valid_o && up_eof_o) nue++;
	end
	function automatic logic [7:0] pat(input int i, input logic [15:0] ty);
		return i == 12 ? ty[15:8] : i == 13 ? ty[7:0] : 8'(8'h40 + i);
	endfunction : pat
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic send(input int n, input logic [15:0] ty);
		fwq.delete();
		upq.delete();
		dsq.delete();
		nmbx = 0;
		nfs = 0;
		nue = 0;
		daq.delete();
		mm_u.frame(n, ty);
		repeat (4) @(negedge clock_i);
	endtask : send
	task automatic ask(input logic [3:0] code, input logic ok, input logic [3:0] st);
		mm_u.req(code);
		chk("ack", al_ack_o, ok);
		chk("err", al_err_o, !ok);
		chk("state", al_state_o, st);
	endtask : ask
	task automatic t_init;
		chk("reset state", al_state_o, AL_INIT);
		chk("reset mbx", mbx_on_o, 1'b0);
		ask(AL_BOOT, 1'b0, AL_INIT);
		ask(AL_OP, 1'b0, AL_INIT);
		ask(AL_PREOP, 1'b0, AL_INIT);
		mm_u.cfg(1'b1, 1'b0);
		ask(AL_PREOP, 1'b1, AL_PREOP);
		chk("mbx on", mbx_on_o, 1'b1);
		$display("init test done");
	endtask : t_init
	task automatic t_preop;
		send(40, ETHERTYPE_FB);
		chk("fw count", fwq.size(), 40);
		for (int i = 0; i < 40; i++) chk("fw byte", fwq[i], pat(i, ETHERTYPE_FB));
		chk("mbx bytes", nmbx, MBX_LEN_DEF);
		chk("mbx first", mfirst, pat(14, ETHERTYPE_FB));
		chk("fw sof", nfs, 1);
		chk("up eof", nue, 1);
		chk("up byte", upq[0], pat(0, ETHERTYPE_FB));
		chk("pd writes", dsq.size(), 0);
		ask(AL_SAFEOP, 1'b0, AL_PREOP);
		$display("preop test done");
	endtask : t_preop
	task automatic t_safeop;
		int w;
		@(negedge clock_i);
		out_wr_i = 1'b1;
		out_data_i = 8'h5a;
		@(negedge clock_i);
		out_wr_i = 1'b0;
		mm_u.cfg(1'b1, 1'b1);
		mm_u.req(AL_SAFEOP);
		chk("copy state", al_state_o, AL_PREOP);
		chk("early ack", al_ack_o, 1'b0);
		for (w = 0; w < PD + 4 && al_ack_o !== 1'b1; w++) @(negedge clock_i);
		chk("copy ack", al_ack_o, 1'b1);
		chk("safe state", al_state_o, AL_SAFEOP);
		send(40, ETHERTYPE_FB);
		chk("tx byte", fwq[30], 8'h5a);
		chk("mbx bytes", nmbx, MBX_LEN_DEF);
		chk("pd writes", dsq.size(), 4);
		for (int i = 0; i < 4; i++) chk("zero input", dsq[i], 8'h00);
		$display("safeop test done");
	endtask : t_safeop
	task automatic t_op;
		ask(AL_OP, 1'b1, AL_OP);
		send(40, ETHERTYPE_FB);
		chk("pd writes", dsq.size(), 4);
		for (int i = 0; i < 4; i++) chk("in copy", dsq[i], pat(30 + i, ETHERTYPE_FB));
		for (int i = 0; i < 4; i++) chk("in addr", daq[i], i);
		chk("tx byte", fwq[30], 8'h5a);
		send(40, 16'h0800);
		chk("other pd", dsq.size(), 0);
		chk("other byte", fwq[30], pat(30, 16'h0800));
		dn_link_i = 1'b0;
		repeat (3) @(negedge clock_i);
		send(20, ETHERTYPE_FB);
		chk("last fw", fwq.size(), 0);
		chk("last up", upq.size(), 20);
		chk("last byte", upq[5], pat(5, ETHERTYPE_FB));
		chk("last eof", nue, 1);
		dn_link_i = 1'b1;
		repeat (3) @(negedge clock_i);
		$display("op test done");
	endtask : t_op
	task automatic t_sync;
		@(negedge clock_i);
		sm_sync_i = 1'b1;
		repeat (10) @(negedge clock_i);
		out_wr_i = 1'b1;
		out_data_i = 8'h77;
		@(negedge clock_i);
		out_wr_i = 1'b0;
		send(40, ETHERTYPE_FB);
		chk("held tx", fwq[30], 8'h5a);
		send(40, ETHERTYPE_FB);
		chk("frame tx", fwq[30], 8'h77);
		sm_sync_i = 1'b0;
		$display("sync test done");
	endtask : t_sync
	task automatic t_fall;
		ask(AL_PREOP, 1'b1, AL_PREOP);
		send(40, ETHERTYPE_FB);
		chk("halted pd", dsq.size(), 0);
		ask(AL_INIT, 1'b1, AL_INIT);
		send(40, ETHERTYPE_FB);
		chk("halted mbx", nmbx, 0);
		chk("mbx off", mbx_on_o, 1'b0);
		$display("fall test done");
	endtask : t_fall
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	initial begin
		rst_i = 1'b1;
		dn_link_i = 1'b1;
		out_wr_i = 1'b0;
		out_addr_i = '0;
		out_data_i = 8'h00;
		repeat (10) @(negedge clock_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clock_i);
		t_init;
		t_preop;
		t_safeop;
		t_op;
		t_sync;
		t_fall;
		complete_run;
	end
	initial begin
		#100us;
		miscompares++;
		complete_run;
	end
endmodule : fbs_slave_sm_tb_top
`default_nettype wire
